// ==== rtl/tpwm_pkg.sv ====
package tpwm_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] TPWM_OFF_CONTROL = 5'h00;
   localparam logic [4:0] TPWM_OFF_SCALER = 5'h04;
   localparam logic [4:0] TPWM_OFF_BOUND = 5'h08;
   localparam logic [4:0] TPWM_OFF_COUNT = 5'h0c;
   localparam logic [4:0] TPWM_OFF_IRQ_STATUS = 5'h10;
   localparam logic [4:0] TPWM_OFF_IRQ_MASK = 5'h14;
   // Reset values
   localparam logic [7:0] TPWM_RST_CONTROL = 8'h00;
   localparam logic [7:0] TPWM_RST_SCALER = 8'h00;
   localparam logic [7:0] TPWM_RST_BOUND = 8'h00;
   localparam logic [7:0] TPWM_RST_COUNT = 8'h00;
   localparam logic [1:0] TPWM_RST_IRQ = 2'h0;
   // Control register fields
   localparam int TPWM_CTL_SRC_HI = 7;
   localparam int TPWM_CTL_SRC_LO = 4;
   localparam int TPWM_CTL_PIN_HI = 3;
   localparam int TPWM_CTL_PIN_LO = 2;
   localparam int TPWM_CTL_PWM = 1;
   // Scaler register fields
   localparam int TPWM_SCL_RES6 = 7;
   localparam int TPWM_SCL_PRE_HI = 6;
   localparam int TPWM_SCL_PRE_LO = 5;
   localparam int TPWM_SCL_DIV_HI = 4;
   localparam int TPWM_SCL_DIV_LO = 0;
   // Interrupt status bits
   localparam int TPWM_IRQ_PERIOD = 0;
   localparam int TPWM_IRQ_PWM = 1;
   // PWM period masks
   localparam logic [7:0] TPWM_MASK_8BIT = 8'hff;
   localparam logic [7:0] TPWM_MASK_7BIT = 8'h7f;
   localparam logic [7:0] TPWM_MASK_6BIT = 8'h3f;
   // Prescaler terminal counts for /1, /4, /16, /64
   localparam logic [5:0] TPWM_PRE_LIM_1 = 6'h00;
   localparam logic [5:0] TPWM_PRE_LIM_4 = 6'h03;
   localparam logic [5:0] TPWM_PRE_LIM_16 = 6'h0f;
   localparam logic [5:0] TPWM_PRE_LIM_64 = 6'h3f;

   // Clock source codes in control[7:4]
   typedef enum logic [3:0] {
      TPWM_SRC_STOP = 4'b0000,
      TPWM_SRC_SYS = 4'b0001,
      TPWM_SRC_HRC = 4'b0010,
      TPWM_SRC_LRC = 4'b0011,
      TPWM_SRC_XTAL = 4'b0100,
      TPWM_SRC_PIN_A = 4'b0101,
      TPWM_SRC_PIN_B = 4'b0110,
      TPWM_SRC_PIN_C = 4'b0111,
      TPWM_SRC_COMP = 4'b1000
   } tpwm_src_t;

   // Output pin codes in control[3:2]
   localparam logic [1:0] TPWM_PIN_NONE = 2'b00;
   localparam logic [1:0] TPWM_PIN_A = 2'b01;
   localparam logic [1:0] TPWM_PIN_B = 2'b10;
   localparam logic [1:0] TPWM_PIN_C = 2'b11;
endpackage : tpwm_pkg

// ==== rtl/tpwm_timer.sv ====
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module tpwm_timer
   import tpwm_pkg::*;
#(
   parameter bit COMPARATOR_GATING_OPTION = 1'b0,
   parameter bit SEVEN_BIT_OPTION = 1'b0
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic high_speed_rc_in,
   input wire logic low_speed_rc_in,
   input wire logic crystal_oscillator_in,
   input wire logic clock_pin_a_in,
   input wire logic clock_pin_b_in,
   input wire logic clock_pin_c_in,
   input wire logic comparator_in,
   output logic pin_out_a_out,
   output logic pin_out_a_en_out,
   output logic pin_out_b_out,
   output logic pin_out_b_en_out,
   output logic pin_out_c_out,
   output logic pin_out_c_en_out,
   output logic irq_out
);

   // Registers
   logic [7:0] timer_control;
   logic [7:0] timer_scaler;
   logic [7:0] timer_upper_bound;
   logic [7:0] timer_count_value;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic bus_ack;
   logic [7:0] src_prev;
   logic [5:0] pre_cnt;
   logic [4:0] div_cnt;
   logic wave;
   logic write_pending;
   logic [7:0] write_value;

   // Bus decode: one wait cycle, then the access completes
   wire bus_req = avs_read_in | avs_write_in;
   wire wr_go = avs_write_in & bus_ack & avs_byteenable_in[0];
   wire sel_ctl = avs_address_in == TPWM_OFF_CONTROL;
   wire sel_scl = avs_address_in == TPWM_OFF_SCALER;
   wire sel_bnd = avs_address_in == TPWM_OFF_BOUND;
   wire sel_cnt = avs_address_in == TPWM_OFF_COUNT;
   wire sel_sts = avs_address_in == TPWM_OFF_IRQ_STATUS;
   wire sel_msk = avs_address_in == TPWM_OFF_IRQ_MASK;
   wire [7:0] wdata = avs_writedata_in[7:0];
   wire [7:0] rd_mux = sel_ctl ? timer_control :
                       sel_scl ? timer_scaler :
                       sel_bnd ? timer_upper_bound :
                       sel_cnt ? timer_count_value :
                       sel_sts ? {6'h00, irq_status} :
                       sel_msk ? {6'h00, irq_mask} : 8'h00;
   assign avs_waitrequest_out = bus_req & ~bus_ack;

   // Field views
   wire [3:0] src_sel = timer_control[TPWM_CTL_SRC_HI:TPWM_CTL_SRC_LO];
   wire [1:0] pin_sel = timer_control[TPWM_CTL_PIN_HI:TPWM_CTL_PIN_LO];
   wire pwm_mode = timer_control[TPWM_CTL_PWM];
   wire res6 = timer_scaler[TPWM_SCL_RES6];
   wire [1:0] pre_sel = timer_scaler[TPWM_SCL_PRE_HI:TPWM_SCL_PRE_LO];
   wire [4:0] div_lim = timer_scaler[TPWM_SCL_DIV_HI:TPWM_SCL_DIV_LO];

   // Refuse period masks that would let a narrow PWM period escape a wider one
   if ((TPWM_MASK_6BIT & ~TPWM_MASK_7BIT) != 8'h00 ||
       (TPWM_MASK_7BIT & ~TPWM_MASK_8BIT) != 8'h00) begin : g_mask_check
      $error("PWM period masks do not nest");
   end

   // Source selection; sampled sources count on rising edges
   wire [7:0] src_now = {comparator_in, clock_pin_c_in, clock_pin_b_in, clock_pin_a_in,
                         crystal_oscillator_in, low_speed_rc_in, high_speed_rc_in, 1'b0};
   wire [7:0] src_rise = src_now & ~src_prev;
   // Codes 2..8 map onto bits 1..7; stop and unused codes never reach the index
   wire [2:0] src_idx = 3'(src_sel - 4'h1);
   wire src_tick = (src_sel == TPWM_SRC_SYS) ? 1'b1 :
                   (src_sel >= TPWM_SRC_HRC && src_sel <= TPWM_SRC_COMP) ?
                   src_rise[src_idx] : 1'b0;

   // Prescaler then scaler produce the count clock enable
   wire [5:0] pre_lim = (pre_sel == 2'd0) ? TPWM_PRE_LIM_1 :
                        (pre_sel == 2'd1) ? TPWM_PRE_LIM_4 :
                        (pre_sel == 2'd2) ? TPWM_PRE_LIM_16 : TPWM_PRE_LIM_64;
   wire pre_tick = src_tick & (pre_cnt >= pre_lim);
   wire count_tick = pre_tick & (div_cnt >= div_lim);

   // Counter next value, period wrap and PWM wrap
   wire [7:0] pwm_mask = ~res6 ? TPWM_MASK_8BIT :
                         SEVEN_BIT_OPTION ? TPWM_MASK_7BIT : TPWM_MASK_6BIT;
   wire [7:0] count_base = write_pending ? write_value : timer_count_value;
   wire period_wrap = ~pwm_mode & ~write_pending &
                      (timer_count_value == timer_upper_bound);
   wire pwm_wrap = pwm_mode & ~write_pending &
                   ((timer_count_value & pwm_mask) == pwm_mask);
   wire [7:0] count_inc = 8'(count_base + 8'h01);
   wire [7:0] next_count = write_pending ? write_value :
                           (period_wrap | pwm_wrap) ? 8'h00 :
                           pwm_mode ? (count_inc & pwm_mask) : count_inc;
   wire period_event = count_tick & period_wrap;
   wire pwm_event = count_tick & pwm_wrap;

   // PWM level: high for counts 0..bound, so bound+1 counts per period
   wire pwm_level = (timer_count_value & pwm_mask) <= timer_upper_bound;
   wire gate_off = COMPARATOR_GATING_OPTION & comparator_in;
   wire next_wave = pwm_mode ? (pwm_level & ~gate_off) :
                    (period_event ? ~wave : wave);

   // Interrupt status: set wins over the write-one clear
   wire [1:0] irq_set = {pwm_event, period_event};
   wire [1:0] irq_clr = (wr_go & sel_sts) ? wdata[1:0] : 2'h0;
   wire [1:0] next_irq_status = irq_set | (irq_status & ~irq_clr);
   assign irq_out = |(irq_status & irq_mask);

   // Pin routing, one slice per pin; unselected pins are released low
   localparam logic [5:0] PIN_CODES = {TPWM_PIN_C, TPWM_PIN_B, TPWM_PIN_A};
   wire [2:0] pin_en;
   wire [2:0] pin_drv;
   for (genvar p = 0; p < 3; p++) begin : g_pin
      assign pin_en[p] = pin_sel == PIN_CODES[2 * p +: 2];
      assign pin_drv[p] = wave & pin_en[p];
   end
   assign pin_out_a_en_out = pin_en[0];
   assign pin_out_b_en_out = pin_en[1];
   assign pin_out_c_en_out = pin_en[2];
   assign pin_out_a_out = pin_drv[0];
   assign pin_out_b_out = pin_drv[1];
   assign pin_out_c_out = pin_drv[2];

   // Bus handshake and read data
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         bus_ack <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (avs_read_in & ~bus_ack) begin
            avs_readdata_out <= {24'h000000, rd_mux};
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         timer_control <= TPWM_RST_CONTROL;
         timer_scaler <= TPWM_RST_SCALER;
         timer_upper_bound <= TPWM_RST_BOUND;
         irq_mask <= TPWM_RST_IRQ;
         irq_status <= TPWM_RST_IRQ;
      end else begin
         if (wr_go & sel_ctl) timer_control <= wdata;
         if (wr_go & sel_scl) timer_scaler <= wdata;
         if (wr_go & sel_bnd) timer_upper_bound <= wdata;
         if (wr_go & sel_msk) irq_mask <= wdata[1:0];
         irq_status <= next_irq_status;
      end
   end

   // Divider chain; counters restart at each terminal tick
   // Limitation: a scaler write keeps the old phase, so the first count
   // clock after it may come early; restarting would cost a compare per field
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         src_prev <= 8'h00;
         pre_cnt <= 6'h00;
         div_cnt <= 5'h00;
      end else begin
         src_prev <= src_now;
         if (pre_tick) pre_cnt <= 6'h00;
         else if (src_tick) pre_cnt <= 6'(pre_cnt + 6'h01);
         if (count_tick) div_cnt <= 5'h00;
         else if (pre_tick) div_cnt <= 5'(div_cnt + 5'h01);
      end
   end

   // Counter, held write and waveform; a write waits for the count clock
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         timer_count_value <= TPWM_RST_COUNT;
         write_pending <= 1'b0;
         write_value <= 8'h00;
         wave <= 1'b0;
      end else begin
         if (wr_go & sel_cnt) begin
            write_pending <= 1'b1;
            write_value <= wdata;
         end else if (count_tick) begin
            write_pending <= 1'b0;
         end
         if (count_tick) timer_count_value <= next_count;
         wave <= next_wave;
      end
   end

   // Checks
   property p_period_wrap;
      @(posedge clk_in) disable iff (reset_in)
      (count_tick & period_wrap & ~(wr_go & sel_cnt)) |=> (timer_count_value == 8'h00);
   endproperty
   a_period_wrap: assert property (p_period_wrap) else $error("period wrap missed");

   property p_count_up;
      @(posedge clk_in) disable iff (reset_in)
      (count_tick & ~write_pending & ~period_wrap & ~pwm_mode)
         |=> (timer_count_value == 8'($past(timer_count_value) + 8'h01));
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter not counting up");

   property p_toggle;
      @(posedge clk_in) disable iff (reset_in)
      (period_event & ~$past(pwm_mode)) |=> (wave != $past(wave));
   endproperty
   a_toggle: assert property (p_toggle) else $error("period output did not toggle");

   sequence s_wrap_seen;
      period_event;
   endsequence
   property p_event_flag;
      @(posedge clk_in) disable iff (reset_in)
      s_wrap_seen |=> irq_status[TPWM_IRQ_PERIOD] ##0
         (irq_mask[TPWM_IRQ_PERIOD] ? irq_out : 1'b1);
   endproperty
   a_event_flag: assert property (p_event_flag) else $error("period event not flagged");

   property p_gate;
      @(posedge clk_in) disable iff (reset_in)
      (COMPARATOR_GATING_OPTION & pwm_mode & comparator_in) |=> (wave == 1'b0);
   endproperty
   a_gate: assert property (p_gate) else $error("PWM not blanked by comparator");

   sequence s_held_write;
      write_pending & count_tick;
   endsequence
   property p_write_load;
      @(posedge clk_in) disable iff (reset_in)
      (s_held_write ##0 ~(wr_go & sel_cnt)) |=> (timer_count_value == $past(write_value));
   endproperty
   a_write_load: assert property (p_write_load) else $error("written count not loaded");

   property p_route;
      @(posedge clk_in) disable iff (reset_in)
      (pin_sel == TPWM_PIN_B) |-> (pin_out_b_out == wave) && !pin_out_a_en_out &&
         !pin_out_c_en_out && !pin_out_a_out && !pin_out_c_out;
   endproperty
   a_route: assert property (p_route) else $error("output routed to wrong pin");

   property p_pwm8_wrap;
      @(posedge clk_in) disable iff (reset_in)
      (count_tick & pwm_mode & ~res6 & ~write_pending & ~(wr_go & sel_cnt) &
         (timer_count_value == 8'hff)) |=> (timer_count_value == 8'h00);
   endproperty
   a_pwm8_wrap: assert property (p_pwm8_wrap) else $error("8-bit PWM period wrong");

   property p_pwm_full;
      @(posedge clk_in) disable iff (reset_in)
      (pwm_mode & ~gate_off & (timer_upper_bound == 8'hff) & $stable(timer_control))
         |=> wave;
   endproperty
   a_pwm_full: assert property (p_pwm_full) else $error("bound 255 not steady high");

   property p_pwm6_mask;
      @(posedge clk_in) disable iff (reset_in)
      (count_tick & pwm_mode & res6 & ~write_pending & ~(wr_go & sel_cnt))
         |=> (timer_count_value <= pwm_mask);
   endproperty
   a_pwm6_mask: assert property (p_pwm6_mask) else $error("6-bit PWM exceeds period");

   // Source ticks between count clocks must equal prescale times scale;
   // the interval right after a scaler write is skipped, its phase is stale
   logic [11:0] chk_src_since;
   logic chk_dirty;
   wire [11:0] chk_span = 12'((12'(pre_lim) + 12'h001) * (12'(div_lim) + 12'h001));
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         chk_src_since <= 12'h000;
         chk_dirty <= 1'b0;
      end else begin
         if (count_tick) chk_src_since <= 12'h000;
         else if (src_tick) chk_src_since <= 12'(chk_src_since + 12'h001);
         if (wr_go & sel_scl) chk_dirty <= 1'b1;
         else if (count_tick) chk_dirty <= 1'b0;
      end
   end

   property p_scaler_chain;
      @(posedge clk_in) disable iff (reset_in)
      (count_tick & ~chk_dirty) |-> (12'(chk_src_since + 12'h001) == chk_span);
   endproperty
   a_scaler_chain: assert property (p_scaler_chain) else $error("count clock off chain");

   // A fresh request waits one cycle, then completes while still held
   sequence s_bus_first;
      bus_req & ~bus_ack;
   endsequence
   property p_one_wait;
      @(posedge clk_in) disable iff (reset_in)
      s_bus_first |-> avs_waitrequest_out ##1 (~bus_req | ~avs_waitrequest_out);
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");

   // Period output may only move at a wrap, which keeps the duty at one half
   property p_half_hold;
      @(posedge clk_in) disable iff (reset_in)
      (~pwm_mode & ~period_event) |=> $stable(wave);
   endproperty
   a_half_hold: assert property (p_half_hold) else $error("period output moved off a wrap");

   // Each sampled source must reach the count chain under its own code
   for (genvar k = 0; k < 7; k++) begin : g_src_chk
      property p_src_rise;
         @(posedge clk_in) disable iff (reset_in)
         (src_sel == 4'(k + 2)) && $rose(src_now[k + 1]) |-> src_tick;
      endproperty
      a_src_rise: assert property (p_src_rise) else $error("source edge not counted");
   end

endmodule : tpwm_timer

// ==== verif/tpwm_partner.sv ====
`timescale 1ns/1ps
// Far side: clock sources, comparator and the load on the output pins
module tpwm_partner (
   input wire logic clk_in,
   output logic [6:0] src_out,
   input wire logic [2:0] pin_in,
   output logic pin_level_out
);
   // All sources idle low
   initial src_out = 7'h00;

   // Released pins sit at the pull-down, so an OR shows the live pin
   assign pin_level_out = |pin_in;

   // High two clocks, low two, so no edge slips past the sampler
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk_in);
         src_out[idx] <= 1'b1;
         repeat (2) @(posedge clk_in);
         src_out[idx] <= 1'b0;
         @(posedge clk_in);
      end
   endtask : pulse

   // Static level, used for the comparator result
   task automatic set_level(input int idx, input logic v);
      @(posedge clk_in);
      src_out[idx] <= v;
   endtask : set_level
endmodule : tpwm_partner

// ==== verif/tpwm_timer_bench.sv ====
`timescale 1ns/1ps
module tpwm_timer_bench;
   import tpwm_pkg::*;
   logic clk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
   logic [4:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, rd;
   logic [3:0] avs_byteenable_in;
   logic [6:0] src;
   logic [2:0] pout, pen;
   logic pin_v;
   int n_fail = 0;
   int tests_run = 0;
   int hi, per;

   tpwm_timer #(.COMPARATOR_GATING_OPTION(1'b1), .SEVEN_BIT_OPTION(1'b0)) u_dut (
      .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .high_speed_rc_in(src[0]), .low_speed_rc_in(src[1]), .crystal_oscillator_in(src[2]),
      .clock_pin_a_in(src[3]), .clock_pin_b_in(src[4]), .clock_pin_c_in(src[5]),
      .comparator_in(src[6]), .pin_out_a_out(pout[0]), .pin_out_a_en_out(pen[0]),
      .pin_out_b_out(pout[1]), .pin_out_b_en_out(pen[1]), .pin_out_c_out(pout[2]),
      .pin_out_c_en_out(pen[2]), .irq_out(irq_out));

   tpwm_partner u_partner (.clk_in(clk_in), .src_out(src), .pin_in(pout & pen),
      .pin_level_out(pin_v));

   // 200 MHz
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One Avalon access; held until waitrequest is sampled low, bounded wait
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
         input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_in);
      avs_address_in <= a;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      avs_writedata_in <= {24'h0, d};
      avs_byteenable_in <= be;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      rd = avs_readdata_out;
      if (n >= 20) n_fail++;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus

   task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask : reg_wr

   task automatic expect_reg(input string what, input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'h1);
      check(what, {24'h0, e}, rd);
   endtask : expect_reg

   task automatic wait_pin(input logic v);
      int n;
      n = 0;
      while (pin_v !== v && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 3000) n_fail++;
   endtask : wait_pin

   // High time and full period in clocks, from one rising edge
   task automatic measure();
      wait_pin(1'b0);
      wait_pin(1'b1);
      hi = 0;
      while (pin_v === 1'b1 && hi < 3000) begin
         @(posedge clk_in);
         hi++;
      end
      per = hi;
      while (pin_v === 1'b0 && per < 3000) begin
         @(posedge clk_in);
         per++;
      end
   endtask : measure

   // Lets the old waveform drain first, then demands a steady level
   task automatic check_const(input string what, input logic v);
      int bad;
      bad = 0;
      repeat (260) @(posedge clk_in);
      repeat (300) begin
         @(posedge clk_in);
         if (pin_v !== v) bad++;
      end
      check(what, 32'h0, bad);
   endtask : check_const

   task automatic t_regs();
      for (int i = 0; i < 7; i++) expect_reg("reset value", 5'(i * 4), 8'h00);
      reg_wr(TPWM_OFF_BOUND, 8'ha5);
      expect_reg("bound", TPWM_OFF_BOUND, 8'ha5);
      reg_wr(TPWM_OFF_SCALER, 8'h5a);
      expect_reg("scaler", TPWM_OFF_SCALER, 8'h5a);
      bus(1'b1, TPWM_OFF_BOUND, 8'h3c, 4'h0);
      expect_reg("bound lane off", TPWM_OFF_BOUND, 8'ha5);
      reg_wr(5'h18, 8'hff);
      expect_reg("unmapped", 5'h18, 8'h00);
      reg_wr(TPWM_OFF_SCALER, 8'h00);
      for (int p = 0; p < 4; p++) begin
         reg_wr(TPWM_OFF_CONTROL, {4'h0, 2'(p), 2'b01});
         expect_reg("control", TPWM_OFF_CONTROL, {4'h0, 2'(p), 2'b01});
         check("pin enable", (p == 0) ? 32'h0 : 32'h1 << (p - 1), {29'h0, pen});
      end
   endtask : t_regs

   // Each sampled source counts; a count write lands on the first tick
   task automatic t_sources();
      reg_wr(TPWM_OFF_BOUND, 8'hff);
      for (int i = 0; i < 7; i++) begin
         reg_wr(TPWM_OFF_CONTROL, {4'(i + 2), 4'h0});
         reg_wr(TPWM_OFF_COUNT, 8'h40);
         u_partner.pulse(i, 4);
         repeat (4) @(posedge clk_in);
         expect_reg("count", TPWM_OFF_COUNT, 8'h43);
      end
   endtask : t_sources

   task automatic t_period();
      reg_wr(TPWM_OFF_BOUND, 8'h03);
      for (int p = 1; p < 4; p++) begin
         reg_wr(TPWM_OFF_CONTROL, {4'h1, 2'(p), 2'b00});
         measure();
         check("period high", 32'd4, hi);
         check("period", 32'd8, per);
      end
      reg_wr(TPWM_OFF_SCALER, 8'h21);
      reg_wr(TPWM_OFF_BOUND, 8'h01);
      measure();
      check("scaled high", 32'd16, hi);
      check("scaled period", 32'd32, per);
      expect_reg("status", TPWM_OFF_IRQ_STATUS, 8'h01);
      check("irq masked", 32'h0, {31'h0, irq_out});
      reg_wr(TPWM_OFF_IRQ_MASK, 8'h01);
      @(posedge clk_in);
      check("irq unmasked", 32'h1, {31'h0, irq_out});
      reg_wr(TPWM_OFF_CONTROL, 8'h00);
      reg_wr(TPWM_OFF_IRQ_STATUS, 8'h01);
      expect_reg("status clear", TPWM_OFF_IRQ_STATUS, 8'h00);
      check("irq clear", 32'h0, {31'h0, irq_out});
      reg_wr(TPWM_OFF_IRQ_MASK, 8'h00);
   endtask : t_period

   task automatic t_pwm();
      reg_wr(TPWM_OFF_SCALER, 8'h00);
      reg_wr(TPWM_OFF_BOUND, 8'h09);
      reg_wr(TPWM_OFF_CONTROL, 8'h16);
      measure();
      check("pwm8 high", 32'd10, hi);
      check("pwm8 period", 32'd256, per);
      bus(1'b0, TPWM_OFF_IRQ_STATUS, 8'h00, 4'h1);
      check("pwm status", 32'h2, rd & 32'h2);
      reg_wr(TPWM_OFF_BOUND, 8'hff);
      check_const("pwm8 full", 1'b1);
      reg_wr(TPWM_OFF_SCALER, 8'h80);
      reg_wr(TPWM_OFF_BOUND, 8'h1f);
      measure();
      check("pwm6 high", 32'd32, hi);
      check("pwm6 period", 32'd64, per);
      reg_wr(TPWM_OFF_BOUND, 8'h00);
      measure();
      check("pwm6 min high", 32'd1, hi);
   endtask : t_pwm

   // Comparator high blanks the output, low brings it back
   task automatic t_gate();
      reg_wr(TPWM_OFF_SCALER, 8'h00);
      reg_wr(TPWM_OFF_BOUND, 8'hff);
      u_partner.set_level(6, 1'b1);
      check_const("gated", 1'b0);
      u_partner.set_level(6, 1'b0);
      check_const("resumed", 1'b1);
   endtask : t_gate

   initial begin
      reset_in = 1'b1;
      avs_address_in = 5'h00;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'h0;
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      t_regs();
      t_sources();
      t_period();
      t_pwm();
      t_gate();
      summarize();
   end

   // Hang guard, well beyond the few thousand clocks the run needs
   initial begin
      repeat (40000) @(posedge clk_in);
      n_fail++;
      summarize();
   end
endmodule : tpwm_timer_bench
